// *** logic/mcta_defines.svh ***
// Purpose: shared constants of the multi-channel timer array
// Assumes: one system clock, counting at the system clock rate except in event and divider modes
// Notes:   widths, channel numbers and count constants only
`ifndef MCTA_DEFINES_SVH
`define MCTA_DEFINES_SVH

`define MCTA_NUM_CH      8        // channels in the array
`define MCTA_CH_PER_UNIT 4        // channels per unit
`define MCTA_CNT_W       16       // channel counter width
`define MCTA_HALF_W      8        // width of one half in split mode
`define MCTA_MODE_W      3        // width of a channel mode code
`define MCTA_DIV_CH      0        // only channel with divider mode
`define MCTA_SPLIT_CH_A  1        // first channel that may split
`define MCTA_SPLIT_CH_B  3        // second channel that may split
`define MCTA_CNT_ZERO    16'h0000 // counter empty
`define MCTA_CNT_ONE     16'h0001 // last count before terminal event
`define MCTA_HALF_ZERO   8'h00    // half counter empty

`endif

// *** logic/mcta_pkg.sv ***
// Purpose: types of the multi-channel timer array
// Assumes: mode codes follow declaration order, 0 upward
// Notes:   mode input bits are cast onto mcta_mode_t
`default_nettype none
package mcta_pkg;

  // channel operating modes, coded 0..7 in this order
  typedef enum logic [2:0] {
    MD_INTERVAL,   // periodic interrupt
    MD_SQUARE,     // toggled output, 50% duty
    MD_EVENT,      // count trigger edges
    MD_DIVIDER,    // channel 0 clock divider
    MD_PULSE_IVL,  // edge to edge capture
    MD_WIDTH,      // level width capture
    MD_DELAY,      // edge started delay
    MD_SLAVE       // pulse started by the master tick
  } mcta_mode_t;

  // channel run state
  typedef enum logic [1:0] {
    ST_STOP,       // disabled
    ST_WAIT,       // armed, waiting for a start event
    ST_RUN         // counting
  } mcta_state_t;

endpackage : mcta_pkg
`default_nettype wire

// *** logic/mcta_edge_if.sv ***
// Purpose: carries synchronised edges of one timer input pin
// Assumes: both ends on the system clock
// Notes:   rise and fall are one-cycle pulses
`timescale 1ns/10ps
`default_nettype none
interface mcta_edge_if;
  logic rise;   // rising edge seen
  logic fall;   // falling edge seen
  modport src (output rise, output fall);
  modport snk (input rise, input fall);
endinterface : mcta_edge_if
`default_nettype wire

// *** logic/mcta_edge.sv ***
// Purpose: synchroniser and edge detector for one timer input pin
// Assumes: pin is asynchronous to the system clock
// Notes:   edges appear two clocks after the pin changes
`timescale 1ns/10ps
`default_nettype none
module mcta_edge (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin,
  mcta_edge_if.src  edge_o
);

  logic meta_q;  // first stage, read only by the second
  logic sync_q;  // second stage
  logic prev_q;  // delayed copy for edge detection

  // two-stage synchroniser, then history
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // edge pulses from the synchronised level
  assign edge_o.rise = sync_q & ~prev_q;
  assign edge_o.fall = ~sync_q & prev_q;

endmodule : mcta_edge
`default_nettype wire

// *** logic/mcta_top.sv ***
// Purpose: eight 16-bit timer channels in two units of four
// Assumes: configuration inputs come from logic on CLK_SYS
// Notes:   counting runs at the CLK_SYS rate except in event and divider modes; no prescaler
`timescale 1ns/10ps
`default_nettype none
`include "mcta_defines.svh"

module mcta_top (
  input  wire logic        CLK_SYS,          // system clock, 100 MHz
  input  wire logic        RST_N,            // asynchronous reset
  input  wire logic [7:0]  CH_ENABLE,        // channel run enable
  input  wire logic [23:0] CH_MODE,          // 3 bits per channel
  input  wire logic [127:0] CH_COMPARE,      // 16 bits per channel
  input  wire logic [7:0]  CH_EDGE_FALL,     // valid edge is falling
  input  wire logic [7:0]  CH_MASTER,        // channel acts as master
  input  wire logic [7:0]  CH_SPLIT,         // 8-bit split, ch 1 and 3
  input  wire logic [7:0]  TRIGGER_PIN,      // count clock or trigger
  input  wire logic        CH0_CLOCK_IN,     // divider clock input
  output logic      [7:0]  CHAN_IRQ,         // interrupt pulses
  output logic      [7:0]  CHAN_IRQ_HI,      // upper half interrupts
  output logic      [7:0]  WAVE_OUT_PIN,     // timer outputs
  output logic             CH0_DIVIDED_OUT,  // divided clock
  output logic      [127:0] CH_CAPTURE       // captured counts
);

  logic [7:0] irq_w;    // per-channel registered interrupt
  logic [7:0] tick_w;   // master tick seen by each channel

  // divider input front end
  mcta_edge_if div_if ();
  mcta_edge u_div_edge (
    .clk    (CLK_SYS),
    .rst_n  (RST_N),
    .pin    (CH0_CLOCK_IN),
    .edge_o (div_if)
  );

  genvar gi;
  generate
    for (gi = 0; gi < `MCTA_NUM_CH; gi++) begin : g_ch
      mcta_edge_if trg_if ();
      mcta_pkg::mcta_mode_t  mode;     // decoded mode
      mcta_pkg::mcta_state_t state_q;  // run state
      logic [15:0] cmp;                // programmed compare
      logic [15:0] cnt_q;              // counter
      logic [15:0] cap_q;              // capture register
      logic        en_q;               // enable history
      logic        start;              // enable rising
      logic        valid_e;            // selected edge
      logic        other_e;            // opposite edge
      logic        tick;               // master tick
      logic        split;              // 8-bit halves active
      logic        irq_d;              // interrupt this cycle
      logic        irq_hi_d;           // upper half interrupt
      logic        irq_q;
      logic        irq_hi_q;
      logic        wave_q;             // output pin level
      localparam bit IS_DIV   = (gi == `MCTA_DIV_CH);
      localparam bit CAN_SPLT = (gi == `MCTA_SPLIT_CH_A) || (gi == `MCTA_SPLIT_CH_B);

      // trigger pin front end
      mcta_edge u_trg_edge (
        .clk    (CLK_SYS),
        .rst_n  (RST_N),
        .pin    (TRIGGER_PIN[gi]),
        .edge_o (trg_if)
      );

      // per-channel config slices; only the master tick comes from a lower channel
      assign mode    = mcta_pkg::mcta_mode_t'(CH_MODE[gi*`MCTA_MODE_W +: `MCTA_MODE_W]);
      assign cmp     = CH_COMPARE[gi*`MCTA_CNT_W +: `MCTA_CNT_W];
      assign start   = CH_ENABLE[gi] & ~en_q;
      assign valid_e = CH_EDGE_FALL[gi] ? trg_if.fall : trg_if.rise;
      assign other_e = CH_EDGE_FALL[gi] ? trg_if.rise : trg_if.fall;
      assign tick    = tick_w[gi];
      assign split   = CAN_SPLT & CH_SPLIT[gi] & (mode == mcta_pkg::MD_INTERVAL);

      // master tick: irq of nearest lower master in the same unit
      if ((gi % `MCTA_CH_PER_UNIT) == 0) begin : g_first
        assign tick_w[gi] = 1'b0;
      end else begin : g_rest
        assign tick_w[gi] = CH_MASTER[gi-1] ? irq_w[gi-1] : tick_w[gi-1];
      end

      // interrupt terms from the current count and input edges
      always_comb begin
        irq_d    = 1'b0;
        irq_hi_d = 1'b0;
        if (CH_ENABLE[gi] && !start) begin
          case (mode)
            mcta_pkg::MD_INTERVAL, mcta_pkg::MD_SQUARE: begin
              if (split) begin
                irq_d    = (cnt_q[7:0] == `MCTA_HALF_ZERO);
                irq_hi_d = (cnt_q[15:8] == `MCTA_HALF_ZERO);
              end else begin
                irq_d = (state_q == mcta_pkg::ST_RUN) && (cnt_q == `MCTA_CNT_ZERO);
              end
            end
            mcta_pkg::MD_EVENT: begin
              irq_d = valid_e && (cnt_q <= `MCTA_CNT_ONE);
            end
            mcta_pkg::MD_DIVIDER: begin
              irq_d = IS_DIV && (div_if.rise | div_if.fall)
                      && (cnt_q <= `MCTA_CNT_ONE);
            end
            mcta_pkg::MD_PULSE_IVL: begin
              irq_d = (state_q == mcta_pkg::ST_RUN) && valid_e;
            end
            mcta_pkg::MD_WIDTH: begin
              irq_d = (state_q == mcta_pkg::ST_RUN) && other_e;
            end
            mcta_pkg::MD_DELAY: begin
              irq_d = (state_q == mcta_pkg::ST_RUN) && (cnt_q == `MCTA_CNT_ZERO);
            end
            mcta_pkg::MD_SLAVE: begin
              irq_d = (state_q == mcta_pkg::ST_RUN) && !tick
                      && (cnt_q == `MCTA_CNT_ONE);
            end
            default: irq_d = 1'b0;
          endcase
        end
      end

      // run state
      always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
          state_q <= mcta_pkg::ST_STOP;
        end else if (!CH_ENABLE[gi]) begin
          state_q <= mcta_pkg::ST_STOP;
        end else if (start) begin
          case (mode)
            mcta_pkg::MD_PULSE_IVL, mcta_pkg::MD_WIDTH,
            mcta_pkg::MD_DELAY, mcta_pkg::MD_SLAVE: state_q <= mcta_pkg::ST_WAIT;
            mcta_pkg::MD_DIVIDER: state_q <= IS_DIV ? mcta_pkg::ST_RUN : mcta_pkg::ST_STOP;
            default: state_q <= mcta_pkg::ST_RUN;
          endcase
        end else begin
          case (mode)
            mcta_pkg::MD_PULSE_IVL: begin
              if (state_q == mcta_pkg::ST_WAIT && valid_e) state_q <= mcta_pkg::ST_RUN;
            end
            mcta_pkg::MD_WIDTH: begin
              if (state_q == mcta_pkg::ST_WAIT && valid_e) begin
                state_q <= mcta_pkg::ST_RUN;
              end else if (state_q == mcta_pkg::ST_RUN && other_e) begin
                state_q <= mcta_pkg::ST_WAIT;
              end
            end
            mcta_pkg::MD_DELAY: begin
              if (state_q == mcta_pkg::ST_WAIT && valid_e) begin
                state_q <= mcta_pkg::ST_RUN;
              end else if (irq_d) begin
                state_q <= mcta_pkg::ST_WAIT;   // rearm for the next edge
              end
            end
            mcta_pkg::MD_SLAVE: begin
              if (tick && cmp != `MCTA_CNT_ZERO) begin
                state_q <= mcta_pkg::ST_RUN;    // master restarts the pulse
              end else if (irq_d) begin
                state_q <= mcta_pkg::ST_WAIT;
              end
            end
            default: state_q <= state_q;
          endcase
        end
      end

      // counter
      always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
          cnt_q <= `MCTA_CNT_ZERO;
        end else if (!CH_ENABLE[gi] || start) begin
          cnt_q <= cmp;
        end else begin
          case (mode)
            mcta_pkg::MD_INTERVAL, mcta_pkg::MD_SQUARE: begin
              if (split) begin
                cnt_q[7:0]  <= irq_d ? cmp[7:0] : cnt_q[7:0] - 8'h01;
                cnt_q[15:8] <= irq_hi_d ? cmp[15:8] : cnt_q[15:8] - 8'h01;
              end else begin
                cnt_q <= irq_d ? cmp : cnt_q - `MCTA_CNT_ONE; // period cmp+1
              end
            end
            mcta_pkg::MD_EVENT: begin
              if (valid_e) cnt_q <= irq_d ? cmp : cnt_q - `MCTA_CNT_ONE;
            end
            mcta_pkg::MD_DIVIDER: begin
              if (div_if.rise | div_if.fall) cnt_q <= irq_d ? cmp : cnt_q - `MCTA_CNT_ONE;
            end
            mcta_pkg::MD_PULSE_IVL: begin
              if (valid_e) begin
                cnt_q <= `MCTA_CNT_ZERO;        // restart on each valid edge
              end else if (state_q == mcta_pkg::ST_RUN) begin
                cnt_q <= cnt_q + `MCTA_CNT_ONE;
              end
            end
            mcta_pkg::MD_WIDTH: begin
              if (state_q == mcta_pkg::ST_WAIT && valid_e) begin
                cnt_q <= `MCTA_CNT_ZERO;
              end else if (state_q == mcta_pkg::ST_RUN) begin
                cnt_q <= cnt_q + `MCTA_CNT_ONE;
              end
            end
            mcta_pkg::MD_DELAY: begin
              if (state_q == mcta_pkg::ST_WAIT && valid_e) begin
                cnt_q <= cmp;
              end else if (state_q == mcta_pkg::ST_RUN && !irq_d) begin
                cnt_q <= cnt_q - `MCTA_CNT_ONE;
              end
            end
            mcta_pkg::MD_SLAVE: begin
              if (tick) begin
                cnt_q <= cmp;                   // duty or pulse width
              end else if (state_q == mcta_pkg::ST_RUN) begin
                cnt_q <= cnt_q - `MCTA_CNT_ONE;
              end
            end
            default: cnt_q <= cnt_q;
          endcase
        end
      end

      // capture register for the measuring modes
      always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
          cap_q <= `MCTA_CNT_ZERO;
        end else if (irq_d && (mode == mcta_pkg::MD_PULSE_IVL || mode == mcta_pkg::MD_WIDTH)) begin
          cap_q <= cnt_q;
        end
      end

      // output pin
      always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
          wave_q <= 1'b0;
        end else if (!CH_ENABLE[gi]) begin
          wave_q <= 1'b0;
        end else if (mode == mcta_pkg::MD_SQUARE || mode == mcta_pkg::MD_DIVIDER) begin
          if (irq_d) wave_q <= ~wave_q;
        end else if (mode == mcta_pkg::MD_SLAVE) begin
          if (tick && cmp != `MCTA_CNT_ZERO) begin
            wave_q <= 1'b1;
          end else if (irq_d) begin
            wave_q <= 1'b0;
          end
        end else begin
          wave_q <= 1'b0;
        end
      end

      // enable history and interrupt pulses
      always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
          en_q     <= 1'b0;
          irq_q    <= 1'b0;
          irq_hi_q <= 1'b0;
        end else begin
          en_q     <= CH_ENABLE[gi];
          irq_q    <= irq_d;
          irq_hi_q <= irq_hi_d;
        end
      end

      assign irq_w[gi]        = irq_q;
      assign CHAN_IRQ[gi]     = irq_q;
      assign CHAN_IRQ_HI[gi]  = irq_hi_q;
      assign WAVE_OUT_PIN[gi] = wave_q;
      assign CH_CAPTURE[gi*`MCTA_CNT_W +: `MCTA_CNT_W] = cap_q;
    end
  endgenerate

  // channel 0 output doubles as the divided clock
  assign CH0_DIVIDED_OUT = WAVE_OUT_PIN[`MCTA_DIV_CH];

endmodule : mcta_top
`default_nettype wire

// *** sim/mcta_top_asserts.sv ***
// Purpose: port-level checks of the timer array
// Assumes: one clock domain, reset active low
// Notes:   bound onto mcta_top at the foot of this file
`timescale 1ns/10ps
`default_nettype none
module mcta_top_asserts (
  input wire logic         CLK_SYS,         // system clock
  input wire logic         RST_N,           // async reset
  input wire logic [7:0]   CH_ENABLE,       // run enables
  input wire logic [23:0]  CH_MODE,         // mode codes
  input wire logic [127:0] CH_COMPARE,      // compare values
  input wire logic [7:0]   CHAN_IRQ,        // interrupt pulses
  input wire logic [7:0]   CHAN_IRQ_HI,     // upper half pulses
  input wire logic [7:0]   WAVE_OUT_PIN,    // timer outputs
  input wire logic         CH0_DIVIDED_OUT, // divided clock
  input wire logic [127:0] CH_CAPTURE       // captured counts
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  logic [15:0] gap_q;  // cycles since last ch0 interrupt
  logic        seen_q; // a first ch0 interrupt was seen

  // period counter for ch0, cleared while stopped
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      gap_q  <= 16'h0000;
      seen_q <= 1'b0;
    end else if (!CH_ENABLE[0]) begin // history dropped on stop
      gap_q  <= 16'h0000;
      seen_q <= 1'b0;
    end else if (CHAN_IRQ[0]) begin // restart at each interrupt
      gap_q  <= 16'h0000;
      seen_q <= 1'b1;
    end else begin
      gap_q  <= gap_q + 16'h0001;
    end
  end

  // slave output rises while set for a width of three
  sequence s_slave_rise;
    $rose(WAVE_OUT_PIN[5]) && CH_MODE[17:15] == 3'h7 && CH_COMPARE[95:80] == 16'h0003
      && CH_COMPARE[79:64] > 16'h0003;
  endsequence
  // three high cycles, then low
  sequence s_slave_body;
    WAVE_OUT_PIN[5] [*3] ##1 !WAVE_OUT_PIN[5];
  endsequence

  ivl_period_a: assert property (
    CHAN_IRQ[0] && seen_q && CH_MODE[2:0] <= 3'h1 |-> gap_q == CH_COMPARE[15:0])
    else $error("ch0 interrupt period wrong");
  irq_single_a: assert property (
    CHAN_IRQ[2] && CH_MODE[8:6] == 3'h0 && CH_COMPARE[47:32] != 16'h0000 |=> !CHAN_IRQ[2])
    else $error("ch2 interrupt longer than one cycle");
  sq_toggle_a: assert property (
    CH_MODE[2:0] == 3'h1 && CH_ENABLE[0] && $past(CH_ENABLE[0])
    |-> $changed(WAVE_OUT_PIN[0]) == CHAN_IRQ[0]) else $error("square toggle not on interrupt");
  div_refuse_a: assert property (
    CH_MODE[5:3] == 3'h3 && $past(CH_MODE[5:3]) == 3'h3 |-> !CHAN_IRQ[1] && !WAVE_OUT_PIN[1])
    else $error("divider ran on ch1");
  div_out_a: assert property (
    CH0_DIVIDED_OUT == WAVE_OUT_PIN[0]
    && (!$changed(CH0_DIVIDED_OUT) || CHAN_IRQ[0] || !$past(CH_ENABLE[0])))
    else $error("divided output moved without a ch0 interrupt");
  split_only_a: assert property ((CHAN_IRQ_HI & 8'hF5) == 8'h00)
    else $error("upper half interrupt on a channel that cannot split");
  quiet_off_a: assert property ((CHAN_IRQ & ~CH_ENABLE & ~$past(CH_ENABLE)) == 8'h00)
    else $error("interrupt from a stopped channel");
  capture_irq_a: assert property (
    CH_ENABLE[0] && $past(CH_ENABLE[0], 2) && $changed(CH_CAPTURE[15:0]) |-> CHAN_IRQ[0])
    else $error("ch0 capture changed without interrupt");
  slave_width_a: assert property (disable iff (!RST_N || !CH_ENABLE[5])
    s_slave_rise |-> s_slave_body) else $error("slave pulse width wrong");
endmodule : mcta_top_asserts

bind mcta_top mcta_top_asserts u_chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
  .CH_ENABLE(CH_ENABLE), .CH_MODE(CH_MODE), .CH_COMPARE(CH_COMPARE), .CHAN_IRQ(CHAN_IRQ),
  .CHAN_IRQ_HI(CHAN_IRQ_HI), .WAVE_OUT_PIN(WAVE_OUT_PIN),
  .CH0_DIVIDED_OUT(CH0_DIVIDED_OUT), .CH_CAPTURE(CH_CAPTURE));
`default_nettype wire

// *** sim/mcta_pin_model.sv ***
// Purpose: pulse sources on the timer input pins
// Assumes: changes just after rising clock edges
// Notes:   pins rest low between trains
`timescale 1ns/10ps
`default_nettype none
module mcta_pin_model (
  input  wire logic       clk,       // system clock
  output var  logic [7:0] trig_pins, // trigger or count pins
  output var  logic       div_clk    // divider clock input
);
  // idle low until a train starts
  initial begin
    trig_pins = 8'h00;
    div_clk   = 1'b0;
  end

  // train on masked pins: hi cycles high, lo cycles low
  task automatic pulse(input logic [7:0] mask, input int hi, input int lo, input int num);
    repeat (num) begin
      @(posedge clk);
      trig_pins <= mask;
      repeat (hi) @(posedge clk);
      trig_pins <= 8'h00;
      repeat (lo - 1) @(posedge clk);
    end
  endtask : pulse

  // count clock, one edge every half cycles
  task automatic clock_div(input int half, input int n);
    repeat (n) begin
      repeat (half) @(posedge clk);
      div_clk <= ~div_clk;
    end
  endtask : clock_div
endmodule : mcta_pin_model
`default_nettype wire

// *** sim/multi_channel_timer_array_tb_top.sv ***
// Purpose: self-checking bench of the timer array
// Assumes: pin model drives trigger and divider pins
// Notes:   plain cases as table rows, then hand tests
`timescale 1ns/10ps
`default_nettype none
module multi_channel_timer_array_tb_top;
  typedef struct packed {
    logic [2:0]  ch;    // channel
    logic [2:0]  mode;  // mode code
    logic [15:0] cmp;   // compare value
    logic        split; // 8-bit split
    logic [7:0]  irq;   // expected interrupts
    logic [7:0]  hi;    // expected upper interrupts
    logic        wave;  // expected final output
  } mcta_row_t;
  // all channels are enabled together for 61 samples
  mcta_row_t rows [8] = '{
    '{3'h0, 3'h1, 16'h0004, 1'b0, 8'h0B, 8'h00, 1'b1}, '{3'h1, 3'h3, 16'h0002, 1'b0, 8'h00, 8'h00, 1'b0},
    '{3'h2, 3'h0, 16'h0009, 1'b0, 8'h05, 8'h00, 1'b0}, '{3'h3, 3'h0, 16'h0409, 1'b1, 8'h05, 8'h0B, 1'b0},
    '{3'h4, 3'h0, 16'h000E, 1'b0, 8'h03, 8'h00, 1'b0}, '{3'h5, 3'h1, 16'h0003, 1'b0, 8'h0E, 8'h00, 1'b0},
    '{3'h6, 3'h0, 16'h001D, 1'b0, 8'h01, 8'h00, 1'b0}, '{3'h7, 3'h0, 16'h00FF, 1'b0, 8'h00, 8'h00, 1'b0}};
  logic         CLK_SYS = 1'b0;               // system clock
  logic         RST_N, CH0_CLOCK_IN, CH0_DIVIDED_OUT, div_q, clr = 1'b1;
  logic [7:0]   CH_ENABLE, CH_EDGE_FALL, CH_MASTER, CH_SPLIT, TRIGGER_PIN;
  logic [7:0]   CHAN_IRQ, CHAN_IRQ_HI, WAVE_OUT_PIN, tg, sp = 8'h00, ms = 8'h00, ef = 8'h00;
  logic [23:0]  CH_MODE, md = 24'h000000;     // mode shadow
  logic [127:0] CH_COMPARE, CH_CAPTURE, cp = 128'h0;
  logic [7:0]   irq_cnt [8], hi_cnt [8], wh_cnt [8]; // per-channel counts
  int           fails = 0, cmp_count = 0, cycles = 0, c;

  always #5 CLK_SYS = ~CLK_SYS;

  mcta_top dut (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .CH_ENABLE(CH_ENABLE), .CH_MODE(CH_MODE),
    .CH_COMPARE(CH_COMPARE), .CH_EDGE_FALL(CH_EDGE_FALL), .CH_MASTER(CH_MASTER),
    .CH_SPLIT(CH_SPLIT), .TRIGGER_PIN(TRIGGER_PIN), .CH0_CLOCK_IN(CH0_CLOCK_IN),
    .CHAN_IRQ(CHAN_IRQ), .CHAN_IRQ_HI(CHAN_IRQ_HI), .WAVE_OUT_PIN(WAVE_OUT_PIN),
    .CH0_DIVIDED_OUT(CH0_DIVIDED_OUT), .CH_CAPTURE(CH_CAPTURE));
  mcta_pin_model u_pins (.clk(CLK_SYS), .trig_pins(TRIGGER_PIN), .div_clk(CH0_CLOCK_IN));

  // settled samples: interrupts, high cycles, divider toggles
  always @(negedge CLK_SYS) begin
    if (clr) begin
      foreach (irq_cnt[i]) begin
        irq_cnt[i] = 8'h00; hi_cnt[i] = 8'h00; wh_cnt[i] = 8'h00;
      end
      tg = 8'h00;
      clr = 1'b0;
    end
    foreach (irq_cnt[i]) begin
      irq_cnt[i] = irq_cnt[i] + {7'h00, CHAN_IRQ[i]};
      hi_cnt[i] = hi_cnt[i] + {7'h00, CHAN_IRQ_HI[i]};
      wh_cnt[i] = wh_cnt[i] + {7'h00, WAVE_OUT_PIN[i]};
    end
    tg = tg + {7'h00, CH0_DIVIDED_OUT ^ div_q};
    div_q = CH0_DIVIDED_OUT;
  end

  // hang guard, far above the expected run
  always @(posedge CLK_SYS) begin
    cycles = cycles + 1;
    if (cycles == 1000) begin
      fails = fails + 1;
      $display("timeout after %0d cycles", cycles);
      final_report();
    end
  end

  task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  // shadow settings of one channel
  task automatic set(input int ch, input logic [2:0] m, input logic [15:0] v);
    md[3*ch +: 3] = m;
    cp[16*ch +: 16] = v;
  endtask : set

  // config while stopped, then enables one edge later
  task automatic start(input logic [7:0] en);
    @(posedge CLK_SYS);
    CH_MODE <= md; CH_COMPARE <= cp; CH_SPLIT <= sp; CH_MASTER <= ms; CH_EDGE_FALL <= ef;
    @(posedge CLK_SYS);
    CH_ENABLE <= en;
    clr = 1'b1;
  endtask : start

  // wait n edges, then read just after the negedge sampler has run
  task automatic hold(input int n);
    repeat (n) @(posedge CLK_SYS);
    @(negedge CLK_SYS);
    #1;
  endtask : hold

  // stop all channels and clear the shadows
  task automatic stop(input string name);
    @(posedge CLK_SYS);
    CH_ENABLE <= 8'h00;
    md = 24'h000000; cp = 128'h0; sp = 8'h00; ms = 8'h00; ef = 8'h00;
    $display("test %s done", name);
  endtask : stop

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  initial begin
    RST_N = 1'b0; CH_ENABLE = 8'h00; CH_MODE = 24'h000000; CH_COMPARE = 128'h0;
    CH_EDGE_FALL = 8'h00; CH_MASTER = 8'h00; CH_SPLIT = 8'h00; div_q = 1'b0;
    repeat (15) @(posedge CLK_SYS);
    @(negedge CLK_SYS);
    chk("outputs in reset", 128'h0, {CHAN_IRQ, CHAN_IRQ_HI, WAVE_OUT_PIN, CH0_DIVIDED_OUT});
    chk("capture in reset", 128'h0, CH_CAPTURE);
    @(posedge CLK_SYS);
    RST_N <= 1'b1;
    hold(1);
    chk("outputs released", 128'h0, {CHAN_IRQ, CHAN_IRQ_HI, WAVE_OUT_PIN, CH0_DIVIDED_OUT});
    $display("test reset done");
    foreach (rows[r]) begin
      c = int'(rows[r].ch);
      set(c, rows[r].mode, rows[r].cmp);
      sp[c] = rows[r].split;
    end
    start(8'hFF);
    hold(60);
    foreach (rows[r]) begin
      c = int'(rows[r].ch);
      chk("irq count", rows[r].irq, irq_cnt[c]);
      chk("upper irq count", rows[r].hi, hi_cnt[c]);
      chk("wave level", rows[r].wave, WAVE_OUT_PIN[c]);
    end
    stop("table rows");
    // capture, event and delay modes on one pulse train
    set(0, 3'h4, 16'h0000); set(2, 3'h2, 16'h0003); set(4, 3'h5, 16'h0000);
    set(6, 3'h6, 16'h0005); set(7, 3'h5, 16'h0000);
    ef = 8'h80;
    start(8'hD5);
    hold(6);
    u_pins.pulse(8'hD5, 7, 13, 3);
    hold(20);
    chk("interval irqs", 8'h02, irq_cnt[0]);
    chk("interval capture", 16'h0013, CH_CAPTURE[15:0]);
    chk("event irqs", 8'h01, irq_cnt[2]);
    chk("high width irqs", 8'h03, irq_cnt[4]);
    chk("high width", 16'h0006, CH_CAPTURE[79:64]);
    chk("delay irqs", 8'h03, irq_cnt[6]);
    chk("low width irqs", 8'h02, irq_cnt[7]);
    chk("low width", 16'h000C, CH_CAPTURE[127:112]);
    stop("pin capture");
    // reset in mid-run clears the held captures
    @(posedge CLK_SYS);
    RST_N <= 1'b0;
    hold(2);
    chk("capture after reset", 128'h0, CH_CAPTURE);
    @(posedge CLK_SYS);
    RST_N <= 1'b1;
    $display("test mid-run reset done");
    // one-shot in unit 0, two-slave PWM in unit 1
    set(0, 3'h6, 16'h0004); set(1, 3'h7, 16'h0005); set(4, 3'h0, 16'h0009);
    set(5, 3'h7, 16'h0003); set(6, 3'h7, 16'h0006);
    ms = 8'h11;
    start(8'h73);
    u_pins.pulse(8'h01, 4, 4, 1);
    hold(52);
    chk("pwm period irqs", 8'h05, irq_cnt[4]);
    chk("pwm duty a", 8'h0F, wh_cnt[5]);
    chk("pwm duty b", 8'h1E, wh_cnt[6]);
    chk("one-shot width", 8'h05, wh_cnt[1]);
    chk("one-shot start", 8'h01, irq_cnt[0]);
    stop("linked channels");
    // channel 0 divider on both input edges
    set(0, 3'h3, 16'h0002);
    start(8'h01);
    u_pins.clock_div(4, 12);
    hold(8);
    chk("divided toggles", 8'h06, tg);
    stop("divider");
    final_report();
  end
endmodule : multi_channel_timer_array_tb_top
`default_nettype wire
